// File: src/dram_special_consts.svh
`ifndef DRAM_SPECIAL_CONSTS_SVH
`define DRAM_SPECIAL_CONSTS_SVH

// System clock period
`define CLK_PERIOD_NS      100

// Parity latency per grade
`define PL_2666            8'h05
`define PL_2933            8'h06
`define PL_3200            8'h06

// Alert pulse width, least and most, per grade
`define ALERT_PW_MIN_2666  8'h50
`define ALERT_PW_MAX_2666  8'hA0
`define ALERT_PW_MIN_2933  8'h58
`define ALERT_PW_MAX_2933  8'hB0
`define ALERT_PW_MIN_3200  8'h60
`define ALERT_PW_MAX_3200  8'hC0

// Alert to deselect-only deadline, persistent mode
`define ALERT_RSP_2666     8'h47
`define ALERT_RSP_2933     8'h4E
`define ALERT_RSP_3200     8'h55

// Chip select to command latency, plain and gear-down
`define CAL_2666           8'h05
`define CAL_2933           8'h06
`define CAL_3200           8'h06
`define CALG_2666          8'h06
`define CALG_2933          8'h08
`define CALG_3200          8'h08

// Mode-register update delay: greater of cycles or time
`define MOD_NCK            24
`define MOD_NS             15
`define MOD_NS_CYC  ((`MOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOD_CYC  ((`MOD_NCK > `MOD_NS_CYC) ? `MOD_NCK : `MOD_NS_CYC)

// Alert assertion slack beyond parity latency (longest, round down)
`define ALERT_ON_NS        6
`define ALERT_ON_RAW       (`ALERT_ON_NS / `CLK_PERIOD_NS)
`define ALERT_ON_CYC       ((`ALERT_ON_RAW < 1) ? 1 : `ALERT_ON_RAW)

// Test enable to chip select low (least, round up)
`define TP_ENABLE_NS       200
`define TP_ENABLE_CYC \
  ((`TP_ENABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Test input to valid output (longest, round down)
`define TP_VALID_NS        200
`define TP_VALID_RAW       (`TP_VALID_NS / `CLK_PERIOD_NS)
`define TP_VALID_CYC       ((`TP_VALID_RAW < 1) ? 1 : `TP_VALID_RAW)

// Bus widths
`define CA_BITS            24
`define TP_IN_BITS         16
`define TP_OUT_BITS        4

`endif

// File: src/dram_special_pkg.sv
`include "dram_special_consts.svh"

package dram_special_pkg;

  // Speed grade select
  typedef enum logic [1:0] {
    GRADE_2666 = 2'b00,
    GRADE_2933 = 2'b01,
    GRADE_3200 = 2'b10
  } grade_t;

  // Max power saving mode states
  typedef enum logic [1:0] {
    SAVE_IDLE   = 2'b00,
    SAVE_ENTRY  = 2'b01,
    SAVE_ACTIVE = 2'b10
  } save_state_t;

  // Grade-dependent cycle limits
  typedef struct packed {
    logic [7:0] pl;
    logic [7:0] pw_min;
    logic [7:0] pw_max;
    logic [7:0] rsp;
    logic [7:0] cal;
    logic [7:0] calg;
  } limits_t;

  // Whole state of the timing block
  typedef struct packed {
    logic                      pl_run;
    logic [7:0]                pl_cnt;
    logic                      alert_on;
    logic [7:0]                pw_cnt;
    logic [7:0]                rsp_cnt;
    logic                      rsp_viol;
    logic [7:0]                cs_hist;
    logic                      cmd_stb;
    logic [`CA_BITS-1:0]       cmd;
    save_state_t               save;
    logic [7:0]                mped_cnt;
    logic                      cke_q;
    logic [7:0]                tpe_cnt;
    logic                      tp_mode;
    logic                      tp_valid;
    logic [`TP_OUT_BITS-1:0]   tp_out;
  } state_t;

endpackage

// File: src/grade_limits.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_special_consts.svh"

module grade_limits
  import dram_special_pkg::*;
(
  input  wire grade_t  grade_i,
  output var limits_t  lim_o
);

  // Table lookup by grade; unknown codes use the fastest grade
  always_comb begin
    case (grade_i)
      GRADE_2666: begin
        lim_o = '{`PL_2666, `ALERT_PW_MIN_2666, `ALERT_PW_MAX_2666,
                  `ALERT_RSP_2666, `CAL_2666, `CALG_2666};
      end
      GRADE_2933: begin
        lim_o = '{`PL_2933, `ALERT_PW_MIN_2933, `ALERT_PW_MAX_2933,
                  `ALERT_RSP_2933, `CAL_2933, `CALG_2933};
      end
      default: begin
        lim_o = '{`PL_3200, `ALERT_PW_MIN_3200, `ALERT_PW_MAX_3200,
                  `ALERT_RSP_3200, `CAL_3200, `CALG_3200};
      end
    endcase
  end

endmodule
`default_nettype wire

// File: src/dram_special_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_special_consts.svh"

module dram_special_timing
  import dram_special_pkg::*;
#(
  parameter int CPDED_CYC = 4   // Command path disable delay, cycles
)(
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  input  wire grade_t                  grade_i,
  input  wire logic                    parity_err_i,
  input  wire logic                    persistent_i,
  input  wire logic                    cs_n_i,
  input  wire logic [`CA_BITS-1:0]     ca_i,
  input  wire logic                    cal_en_i,
  input  wire logic                    gear_down_i,
  input  wire logic                    save_entry_i,
  input  wire logic                    cke_i,
  input  wire logic                    test_enable_input_i,
  input  wire logic [`TP_IN_BITS-1:0]  tp_in_i,
  output logic                         alert_n_o,
  output logic                         rsp_viol_o,
  output logic                         cmd_stb_o,
  output logic [`CA_BITS-1:0]          cmd_o,
  output logic                         cmd_path_en_o,
  output logic                         max_power_saving_mode_o,
  output logic                         connectivity_test_mode_o,
  output logic                         tp_valid_o,
  output logic [`TP_OUT_BITS-1:0]      tp_out_o
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check: entry count must fit eight bits
  if (CPDED_CYC < 1 || CPDED_CYC > 200) begin : g_bad_cpded
    $error("CPDED_CYC out of range 1..200");
  end

  localparam logic [7:0] MPED_CYC = 8'(`MOD_CYC + CPDED_CYC);
  localparam logic [7:0] TP_EN_CYC = 8'(`TP_ENABLE_CYC);

  state_t                   s_ff;       // Registered state
  state_t                   nxt_s;      // Next state
  limits_t                  lim;        // Grade limits
  logic [`TP_OUT_BITS-1:0]  fold;       // Folded test inputs
  logic [7:0]               lat;        // Active CAL latency
  logic                     capture;    // Command captured now

  ////////////////////////////////////////////////////////////////////////
  // grade table lookup
  grade_limits u_lim (
    .grade_i (grade_i),
    .lim_o   (lim)
  );

  // Each test output is the parity of four test inputs
  genvar gi;
  for (gi = 0; gi < `TP_OUT_BITS; gi++) begin : g_fold
    assign fold[gi] = ^tp_in_i[4*gi +: 4];
  end

  assign lat = gear_down_i ? lim.calg : lim.cal;

  // capture after CAL cycles, else with select
  assign capture = cal_en_i ? s_ff.cs_hist[3'(lat - 8'h01)] : ~cs_n_i;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.cmd_stb  = 1'b0;
    nxt_s.rsp_viol = 1'b0;
    nxt_s.cke_q    = cke_i;
    nxt_s.cs_hist  = {s_ff.cs_hist[6:0], ~cs_n_i};

    // Parity alert sequencing
    if (s_ff.pl_run) begin
      // alert as the parity latency runs out, pl cycles after the error
      if (s_ff.pl_cnt == 8'h01) begin
        nxt_s.pl_run   = 1'b0;
        nxt_s.alert_on = 1'b1;
        nxt_s.pw_cnt   = lim.pw_min;
        nxt_s.rsp_cnt  = 8'h00;
      end else begin
        nxt_s.pl_cnt = s_ff.pl_cnt - 8'h01;
      end
    end else if (s_ff.alert_on) begin
      // hold alert for the least pulse width
      if (s_ff.pw_cnt == 8'h01) begin
        nxt_s.alert_on = 1'b0;
      end else begin
        nxt_s.pw_cnt = s_ff.pw_cnt - 8'h01;
      end
      if (s_ff.rsp_cnt != 8'hFF) begin
        nxt_s.rsp_cnt = s_ff.rsp_cnt + 8'h01;
      end
      // flag a command past the deselect deadline
      if (persistent_i && s_ff.rsp_cnt >= lim.rsp && !cs_n_i) begin
        nxt_s.rsp_viol = 1'b1;
      end
    end else if (parity_err_i) begin
      // New error starts the latency count
      nxt_s.pl_run = 1'b1;
      nxt_s.pl_cnt = lim.pl;
    end

    // Command capture while the command path is on
    if (capture && s_ff.save != SAVE_ACTIVE) begin
      nxt_s.cmd_stb = 1'b1;
      nxt_s.cmd     = ca_i;
    end

    // Max power saving mode
    case (s_ff.save)
      SAVE_IDLE: begin
        // entry delay built on the update delay
        if (save_entry_i) begin
          nxt_s.save     = SAVE_ENTRY;
          nxt_s.mped_cnt = MPED_CYC;
        end
      end
      SAVE_ENTRY: begin
        // path stays on for update plus disable
        if (s_ff.mped_cnt == 8'h01) begin
          nxt_s.save = SAVE_ACTIVE;
        end else begin
          nxt_s.mped_cnt = s_ff.mped_cnt - 8'h01;
        end
      end
      SAVE_ACTIVE: begin
        // Rising clock enable wakes the device
        if (cke_i && !s_ff.cke_q) begin
          nxt_s.save = SAVE_IDLE;
        end
      end
      default: begin
        nxt_s.save = SAVE_IDLE;
      end
    endcase

    // Connectivity test entry and output
    if (!test_enable_input_i) begin
      nxt_s.tpe_cnt  = 8'h00;
      nxt_s.tp_mode  = 1'b0;
      nxt_s.tp_valid = 1'b0;
    end else begin
      if (s_ff.tpe_cnt != 8'hFF) begin
        nxt_s.tpe_cnt = s_ff.tpe_cnt + 8'h01;
      end
      if (!cs_n_i && s_ff.tpe_cnt >= TP_EN_CYC) begin
        nxt_s.tp_mode = 1'b1;
      end
      // outputs follow inputs one cycle later
      nxt_s.tp_valid = s_ff.tp_mode && !cs_n_i;
      if (s_ff.tp_mode) begin
        nxt_s.tp_out = fold;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from state
  assign alert_n_o                = ~s_ff.alert_on;
  assign rsp_viol_o               = s_ff.rsp_viol;
  assign cmd_stb_o                = s_ff.cmd_stb;
  assign cmd_o                    = s_ff.cmd;
  assign cmd_path_en_o            = (s_ff.save != SAVE_ACTIVE);
  assign max_power_saving_mode_o  = (s_ff.save == SAVE_ACTIVE);
  assign connectivity_test_mode_o = s_ff.tp_mode;
  assign tp_valid_o               = s_ff.tp_valid;
  assign tp_out_o                 = s_ff.tp_out;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic [7:0] low_len_ff;  // Length of current alert pulse
  logic [7:0] entry_age_ff; // Cycles since power-saving entry
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      low_len_ff   <= 8'h00;
      entry_age_ff <= 8'h00;
    end else begin
      low_len_ff   <= alert_n_o ? 8'h00 : low_len_ff + 8'h01;
      entry_age_ff <= (s_ff.save == SAVE_IDLE) ? 8'h00 :
                      (entry_age_ff + 8'h01);
    end
  end

  sequence err_taken_s;
    parity_err_i && !s_ff.pl_run && !s_ff.alert_on;
  endsequence

  alert_width_a: assert property (
    $rose(alert_n_o) |-> low_len_ff >= $past(lim.pw_min) &&
                         low_len_ff <= $past(lim.pw_max))
    else $error("alert pulse width out of range");

  alert_delay_a: assert property (
    err_taken_s |-> alert_n_o [*5] ##[1:3] !alert_n_o)
    else $error("alert not asserted after parity latency");

  cal_capture_a: assert property (
    (cal_en_i && !gear_down_i && grade_i == GRADE_2666 &&
     !s_ff.cs_hist[4] && !cs_n_i) |-> !capture ##1 1'b1)
    else $error("command taken too early in latency mode");

  calg_capture_a: assert property (
    (cal_en_i && gear_down_i && grade_i != GRADE_2666 &&
     s_ff.cs_hist[7] && max_power_saving_mode_o == 1'b0)
    |=> cmd_stb_o)
    else $error("gear-down command not taken at latency");

  path_disable_a: assert property (
    $fell(cmd_path_en_o) |-> entry_age_ff == MPED_CYC)
    else $error("command path disabled at wrong time");

  mod_delay_a: assert property (
    (s_ff.save == SAVE_IDLE && save_entry_i) |=> cmd_path_en_o [*8])
    else $error("command path dropped inside update delay");

  probe_valid_a: assert property (
    (s_ff.tp_mode && !cs_n_i && test_enable_input_i)
    ##1 (!cs_n_i && test_enable_input_i) |-> tp_valid_o)
    else $error("test output not valid in time");

  grade_pw_a: assert property (
    $rose(s_ff.alert_on) && grade_i == $past(grade_i) |->
      s_ff.pw_cnt == lim.pw_min)
    else $error("alert width not taken from grade");

  test_entry_a: assert property (
    $rose(connectivity_test_mode_o) |-> $past(s_ff.tpe_cnt) >= TP_EN_CYC)
    else $error("test mode entered too early");

endmodule
`default_nettype wire

// File: verif/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_special_consts.svh"

module ctrl_model (
  input  wire logic                clk_sys_i,
  output logic                     cs_n_o,
  output logic [`CA_BITS-1:0]      ca_o
);
  //////////////////////////////////////////////////////////////////////////
  // Idle bus: deselected, address lines parked on a non-command pattern
  // deselect when idle
  initial begin
    cs_n_o = 1'b1;
    ca_o   = 24'h5A5A5A;
  end

  //////////////////////////////////////////////////////////////////////////
  // Select for one cycle, present the command lat cycles later
  // latency honoured
  task automatic issue(input int lat, input logic [`CA_BITS-1:0] v);
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    ca_o   = ~v;
    @(negedge clk_sys_i);
    cs_n_o = 1'b1;
    repeat (lat - 1) @(negedge clk_sys_i);
    ca_o = v;
    @(negedge clk_sys_i);
    ca_o = ~v;
  endtask
endmodule
`default_nettype wire

// File: verif/dram_special_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dram_special_consts.svh"

module dram_special_timing_tb;
  import dram_special_pkg::*;
  localparam int CPDED = 4;          // Short disable delay
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic parity_err_i = 1'b0;
  logic persistent_i = 1'b0;
  logic cs_tb = 1'b1;                // Bench-side select
  logic cal_en_i = 1'b0;
  logic gear_down_i = 1'b0;
  logic save_entry_i = 1'b0;
  logic cke_i = 1'b1;
  logic test_enable_input_i = 1'b0;
  logic [15:0] tp_in_i = 16'h0000;
  grade_t grade_i = GRADE_2666;
  logic alert_n_o, rsp_viol_o, cmd_stb_o, cmd_path_en_o;
  logic max_power_saving_mode_o, connectivity_test_mode_o, tp_valid_o;
  logic [23:0] cmd_o;
  logic [3:0] tp_out_o;
  logic [3:0] tp_exp;
  wire logic model_cs_n;
  wire logic cs_n_i;
  wire logic [23:0] ca_i;
  int n_fail = 0;
  int total_checks = 0;
  int n, w, viol, vw, lat;
  int pl_t[3] = '{5, 6, 6};
  int pw_t[3] = '{80, 88, 96};
  int cal_t[3] = '{5, 6, 6};
  int calg_t[3] = '{6, 8, 8};
  logic [23:0] v;

  // Select is low when either party pulls it low
  assign cs_n_i = cs_tb & model_cs_n;
  always #50 clk_sys_i = ~clk_sys_i;

  dram_special_timing #(.CPDED_CYC(CPDED)) i_dram_special_timing (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .grade_i(grade_i),
    .parity_err_i(parity_err_i), .persistent_i(persistent_i),
    .cs_n_i(cs_n_i), .ca_i(ca_i), .cal_en_i(cal_en_i),
    .gear_down_i(gear_down_i), .save_entry_i(save_entry_i),
    .cke_i(cke_i), .test_enable_input_i(test_enable_input_i),
    .tp_in_i(tp_in_i), .alert_n_o(alert_n_o), .rsp_viol_o(rsp_viol_o),
    .cmd_stb_o(cmd_stb_o), .cmd_o(cmd_o), .cmd_path_en_o(cmd_path_en_o),
    .max_power_saving_mode_o(max_power_saving_mode_o),
    .connectivity_test_mode_o(connectivity_test_mode_o),
    .tp_valid_o(tp_valid_o), .tp_out_o(tp_out_o));

  ctrl_model i_ctrl_model (
    .clk_sys_i(clk_sys_i), .cs_n_o(model_cs_n), .ca_o(ca_i));

  //////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask

  // Print counts and verdict, end the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One cycle of a bounded wait
  task automatic tick(inout int c);
    @(negedge clk_sys_i);
    c++;
    if (c > 400) begin
      chk("wait bound", 0, 1);
      give_verdict();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys_i);
    srst_i = 1'b0;
    @(negedge clk_sys_i);
    chk("alert idle", 1, alert_n_o);
    chk("path idle", 1, cmd_path_en_o);
    chk("mode idle", 0, max_power_saving_mode_o);
    $display("test reset done");
    // Alert delay and width per grade, late command in persistent mode
    for (int g = 0; g < 3; g++) begin
      grade_i = grade_t'(g);
      persistent_i = (g == 0);
      viol = 0;
      vw = 0;
      parity_err_i = 1'b1;
      @(negedge clk_sys_i);
      parity_err_i = 1'b0;
      n = 0;
      while (alert_n_o !== 1'b0) tick(n);
      chk("alert delay", pl_t[g], n);
      w = 0;
      while (alert_n_o === 1'b0) begin
        cs_tb = !(g == 0 && (w == 10 || w == 75));
        tick(w);
        if (rsp_viol_o === 1'b1) begin
          viol++;
          vw = w;
        end
      end
      cs_tb = 1'b1;
      chk("alert width", pw_t[g], w);
      chk("late flags", (g == 0), viol);
      if (g == 0) chk("late flag time", 1, vw >= 76 && vw <= 78);
    end
    persistent_i = 1'b0;
    $display("test alert done");
    // Select to command latency, plain and gear-down, every grade
    cal_en_i = 1'b1;
    for (int g = 0; g < 3; g++) begin
      for (int gd = 0; gd < 2; gd++) begin
        grade_i = grade_t'(g);
        gear_down_i = gd[0];
        lat = gd ? calg_t[g] : cal_t[g];
        v = 24'hC00000 | (g << 4) | gd;
        i_ctrl_model.issue(lat, v);
        chk("strobe", 1, cmd_stb_o);
        chk("command", v, cmd_o);
        @(negedge clk_sys_i);
        chk("strobe once", 0, cmd_stb_o);
      end
    end
    cal_en_i = 1'b0;
    $display("test latency done");
    // Power saving entry, refused command, exit on enable rise
    save_entry_i = 1'b1;
    @(negedge clk_sys_i);
    save_entry_i = 1'b0;
    n = 0;
    while (cmd_path_en_o !== 1'b0) tick(n);
    chk("path off delay", `MOD_CYC + CPDED, n);
    chk("saving mode", 1, max_power_saving_mode_o);
    i_ctrl_model.issue(1, 24'h00F00F);
    chk("refused strobe", 0, cmd_stb_o);
    chk("refused command", v, cmd_o);
    // clock runs, select high through exit
    cke_i = 1'b0;
    @(negedge clk_sys_i);
    cke_i = 1'b1;
    n = 0;
    while (cmd_path_en_o !== 1'b1) tick(n);
    chk("exit delay", 1, n);
    chk("saving left", 0, max_power_saving_mode_o);
    repeat (4) @(negedge clk_sys_i);
    $display("test power saving done");
    // Connectivity test: early select refused, then fold outputs
    // enable leads select, clock enable high
    test_enable_input_i = 1'b1;
    @(negedge clk_sys_i);
    cs_tb = 1'b0;
    @(negedge clk_sys_i);
    cs_tb = 1'b1;
    @(negedge clk_sys_i);
    chk("test mode early", 0, connectivity_test_mode_o);
    cs_tb = 1'b0;
    tp_in_i = 16'h1234;
    for (int i = 0; i < 4; i++) tp_exp[i] = ^tp_in_i[4*i +: 4];
    @(negedge clk_sys_i);
    chk("test mode", 1, connectivity_test_mode_o);
    @(negedge clk_sys_i);
    chk("test valid", 1, tp_valid_o);
    chk("test out", tp_exp, tp_out_o);
    tp_in_i = 16'h8421;
    for (int i = 0; i < 4; i++) tp_exp[i] = ^tp_in_i[4*i +: 4];
    @(negedge clk_sys_i);
    chk("test valid held", 1, tp_valid_o);
    chk("test out new", tp_exp, tp_out_o);
    cs_tb = 1'b1;
    test_enable_input_i = 1'b0;
    @(negedge clk_sys_i);
    chk("test mode off", 0, connectivity_test_mode_o);
    chk("test valid off", 0, tp_valid_o);
    $display("test connectivity done");
    give_verdict();
  end
endmodule
`default_nettype wire
